// *** dv/fps_top_asserts.sv ***
// port checker for the program counter sequencer
`timescale 1ns/1ns
module fps_top_asserts
    import fps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic ex_jump,
    input wire logic ex_call,
    input wire logic ex_ret,
    input wire logic ex_skip,
    input wire logic ex_pc_low_wr,
    input wire logic [7:0] ex_pc_low_data,
    input wire logic [11:0] ex_target,
    input wire logic [11:0] ex_stack_pc,
    input wire logic int_ack,
    input wire logic [1:0] int_src,
    input wire logic wake_evt,
    input wire logic [11:0] fetch_addr,
    input wire logic fetch_strobe,
    input wire logic [3:0] phase_clks,
    input wire logic exec_valid,
    input wire logic stack_push,
    input wire logic [11:0] stack_push_data,
    input wire logic stack_pop,
    input wire logic running
);
    logic do_int, do_br, do_ret, do_low, do_skip;
    logic [11:0] vec, low_new, wake_cnt_q;
    assign do_int = exec_valid && int_ack;
    assign do_br = exec_valid && !int_ack && (ex_jump || ex_call);
    assign do_ret = exec_valid && !int_ack && !ex_jump && !ex_call && ex_ret;
    assign do_low = exec_valid && !int_ack && !ex_jump && !ex_call && !ex_ret && ex_pc_low_wr;
    assign do_skip = exec_valid && !(int_ack || ex_jump || ex_call || ex_ret || ex_pc_low_wr)
        && ex_skip;
    assign vec = {7'h00, {1'b0, int_src} + 3'h1, 2'h0};
    assign low_new = {fetch_addr[11:8], ex_pc_low_data};
    // cycles since wake-up was requested while asleep
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wake_cnt_q <= 12'h000;
        end else if (running) begin
            wake_cnt_q <= 12'h000;
        end else if (wake_evt || wake_cnt_q != 12'h000) begin
            wake_cnt_q <= wake_cnt_q + 12'h001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_phase_onehot; $onehot(phase_clks); endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");
    property p_strobe_gap; fetch_strobe |=> !fetch_strobe [*3]; endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("fetch too soon");
    property p_seq_inc; fetch_strobe && exec_valid |-> fetch_addr == $past(fetch_addr) + 12'h001;
    endproperty
    a_seq_inc: assert property (p_seq_inc) else $error("no increment");
    property p_branch; fetch_strobe && $past(do_br) |-> fetch_addr == $past(ex_target) && !exec_valid;
    endproperty
    a_branch: assert property (p_branch) else $error("branch target");
    property p_ret; fetch_strobe && $past(do_ret) |-> fetch_addr == $past(ex_stack_pc) && stack_pop;
    endproperty
    a_ret: assert property (p_ret) else $error("return address");
    property p_low; fetch_strobe && $past(do_low) |-> fetch_addr == $past(low_new) && !exec_valid;
    endproperty
    a_low: assert property (p_low) else $error("low byte load");
    property p_skip; fetch_strobe && $past(do_skip) |-> !exec_valid
        && fetch_addr == $past(fetch_addr) + 12'h001; endproperty
    a_skip: assert property (p_skip) else $error("skip");
    property p_int_vec; fetch_strobe && $past(do_int) |-> fetch_addr == $past(vec)
        && stack_push && stack_push_data == $past(fetch_addr); endproperty
    a_int_vec: assert property (p_int_vec) else $error("vector");
    property p_dummy; fetch_strobe && !$past(exec_valid) |-> !stack_push && !stack_pop; endproperty
    a_dummy: assert property (p_dummy) else $error("dummy had effect");
    property p_wake; $rose(running) |-> wake_cnt_q >= 12'h400 && wake_cnt_q <= 12'h410; endproperty
    a_wake: assert property (p_wake) else $error("start-up wait");
    property p_apb; psel && penable && !pready |=> pready; endproperty
    a_apb: assert property (p_apb) else $error("no apb answer");
    c_branch: cover property (fetch_strobe && $past(do_br));
    c_int: cover property (fetch_strobe && $past(do_int));
    c_wake: cover property ($rose(running));
endmodule : fps_top_asserts

bind fps_top fps_top_asserts u_chk (.clk_sys, .resetn, .psel, .penable, .pready, .ex_jump,
    .ex_call, .ex_ret, .ex_skip, .ex_pc_low_wr, .ex_pc_low_data, .ex_target, .ex_stack_pc, .int_ack,
    .int_src, .wake_evt, .fetch_addr, .fetch_strobe, .phase_clks, .exec_valid, .stack_push,
    .stack_push_data, .stack_pop, .running);

// *** dv/tb.sv ***
// self-checking bench for the program counter sequencer
`timescale 1ns/1ns
module tb
    import fps_pkg::*;
;
    typedef struct packed {
        logic [5:0] op;
        logic [1:0] src;
        logic [11:0] val;
        logic [11:0] addr;
        logic valid;
        logic [1:0] st;
    } fps_row_t;
    localparam int NROWS = 19;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr, ex_target, ex_stack_pc, fetch_addr, stack_push_data, prev;
    logic [31:0] pwdata, prdata, rd;
    logic ex_jump, ex_call, ex_ret, ex_skip, ex_pc_low_wr, int_ack, halt_req, wake_evt;
    logic [7:0] ex_pc_low_data;
    logic [1:0] int_src;
    logic [3:0] phase_clks;
    logic fetch_strobe, exec_valid, stack_push, stack_pop, running;
    int fail_count, checked, cycles, n;
    // op bits: interrupt, jump, call, return, skip, low byte write
    fps_row_t rows [NROWS] = '{
        '{6'h00, 2'h0, 12'h000, 12'h002, 1'h1, 2'h0},
        '{6'h12, 2'h0, 12'h345, 12'h345, 1'h0, 2'h0},
        '{6'h10, 2'h0, 12'h111, 12'h346, 1'h1, 2'h0},
        '{6'h02, 2'h0, 12'h000, 12'h347, 1'h0, 2'h0},
        '{6'h00, 2'h0, 12'h000, 12'h348, 1'h1, 2'h0},
        '{6'h01, 2'h0, 12'h0FF, 12'h3FF, 1'h0, 2'h0},
        '{6'h00, 2'h0, 12'h000, 12'h400, 1'h1, 2'h0},
        '{6'h08, 2'h0, 12'h7F0, 12'h7F0, 1'h0, 2'h2},
        '{6'h00, 2'h0, 12'h000, 12'h7F1, 1'h1, 2'h0},
        '{6'h04, 2'h0, 12'h400, 12'h400, 1'h0, 2'h1},
        '{6'h00, 2'h0, 12'h000, 12'h401, 1'h1, 2'h0},
        '{6'h30, 2'h0, 12'h222, 12'h004, 1'h0, 2'h2},
        '{6'h00, 2'h0, 12'h000, 12'h005, 1'h1, 2'h0},
        '{6'h20, 2'h1, 12'h000, 12'h008, 1'h0, 2'h2},
        '{6'h00, 2'h0, 12'h000, 12'h009, 1'h1, 2'h0},
        '{6'h20, 2'h2, 12'h000, 12'h00C, 1'h0, 2'h2},
        '{6'h00, 2'h0, 12'h000, 12'h00D, 1'h1, 2'h0},
        '{6'h20, 2'h3, 12'h000, 12'h010, 1'h0, 2'h2},
        '{6'h00, 2'h0, 12'h000, 12'h011, 1'h1, 2'h0}};
    fps_top uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ex_jump, .ex_call, .ex_ret, .ex_skip, .ex_pc_low_wr, .ex_pc_low_data,
        .ex_target, .ex_stack_pc, .int_ack, .int_src, .halt_req, .wake_evt, .fetch_addr,
        .fetch_strobe, .phase_clks, .exec_valid, .stack_push, .stack_push_data, .stack_pop,
        .running);
    task automatic wrap_up();
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // one apb transfer, held until pready, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        check("pready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    // wait for the next fetch and compare its results
    task automatic next_fetch(input logic [11:0] addr, input logic valid, input logic [1:0] st);
        n = 0;
        while (fetch_strobe !== 1'b1 && n < 12) begin
            @(posedge clk_sys);
            n++;
        end
        check("fetch_strobe", 1'b1, fetch_strobe);
        check("fetch_addr", addr, fetch_addr);
        check("exec_valid", valid, exec_valid);
        check("push_pop", st, {stack_push, stack_pop});
    endtask : next_fetch
    task automatic wait_run(input logic lvl);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (running !== lvl && n < 1200);
    endtask : wait_run
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, halt_req, wake_evt} = '0;
        {ex_jump, ex_call, ex_ret, ex_skip, ex_pc_low_wr, int_ack, int_src} = '0;
        {ex_pc_low_data, ex_target, ex_stack_pc} = '0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("pc_low_reset", 32'h0000_0000, rd);
        next_fetch(12'h001, 1'b1, 2'h0);
        prev = 12'h001;
        for (int i = 0; i < NROWS; i++) begin
            {int_ack, ex_jump, ex_call, ex_ret, ex_skip, ex_pc_low_wr} <= rows[i].op;
            int_src <= rows[i].src;
            ex_target <= rows[i].val;
            ex_stack_pc <= rows[i].val;
            ex_pc_low_data <= rows[i].val[7:0];
            @(posedge clk_sys);
            next_fetch(rows[i].addr, rows[i].valid, rows[i].st);
            if (rows[i].st[1]) begin
                check("push_data", prev, stack_push_data);
            end
            prev = rows[i].addr;
        end
        apb(1'b1, 12'h000, 32'h0000_0040);
        next_fetch(12'h012, 1'b1, 2'h0);
        @(posedge clk_sys);
        next_fetch(12'h040, 1'b0, 2'h0);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("pc_low_read", 32'h0000_0040, rd);
        next_fetch(12'h041, 1'b1, 2'h0);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check("slverr", 1'b1, err);
        apb(1'b1, 12'h008, 32'h0000_0003);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("cfg", 32'h0000_0002, rd);
        halt_req <= 1'b1;
        wait_run(1'b0);
        check("running", 1'b0, running);
        halt_req <= 1'b0;
        wake_evt <= 1'b1;
        wait_run(1'b1);
        wake_evt <= 1'b0;
        check("wake_wait", 1'b1, n >= 1024 && n <= 1032);
        resetn <= 1'b0;
        @(posedge clk_sys);
        check("fetch_addr", 12'h000, fetch_addr);
        check("exec_valid", 1'b0, exec_valid);
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        next_fetch(12'h001, 1'b1, 2'h0);
        wrap_up();
    end
endmodule : tb

// *** rtl/fps_ctl_if.sv ***
// control carrier between the sequencer, phase ring and start-up timer
`timescale 1ns/1ns
interface fps_ctl_if;
    logic run;
    logic [3:0] phase;
    logic boundary;
    logic wake_go;
    logic startup_done;

    modport seq (output run, output wake_go, input phase, input boundary, input startup_done);
    modport ring (input run, output phase, output boundary);
    modport timer (input wake_go, output startup_done);
endinterface : fps_ctl_if

// *** rtl/fps_phase_ring.sv ***
// four-phase one-hot ring that marks the instruction cycle
`timescale 1ns/1ns
module fps_phase_ring
    import fps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    fps_ctl_if.ring ctl
);
    logic [3:0] phase_q;
    logic [3:0] phase_d;

    always_comb begin
        phase_d = phase_q;
        if (ctl.run) begin
            phase_d = {phase_q[2:0], phase_q[3]};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_q <= PHASE_RESET;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign ctl.phase = phase_q;
    // last phase while running: next edge starts a new instruction cycle
    assign ctl.boundary = phase_q[3] & ctl.run;
endmodule : fps_phase_ring

// *** rtl/fps_pkg.sv ***
// constants and types for the fetch pipeline and program counter sequencer
// Overview of operation
// - four non-overlapping phase clocks; one full sequence is one instruction cycle
// - counter advances at start of phase one, fetch then; phases two to four execute (phase_clks output lags a cycle, so it shows phase four at fetch_strobe)
// - next fetch overlaps current execution; sequential instructions take one cycle
// - jumps and calls take two cycles: obtain target, then branch
// - counter adds one per instruction unless execution is redirected
// - taken skip discards prefetched instruction, inserts dummy, counter reaches address plus two
// - only low counter byte is readable and writable; writes keep upper bits (the status register also reads the full counter)
// - any write to the low counter byte inserts one dummy cycle
// - jumps, calls, interrupts and reset load the full target address
// - wake-up from power-down waits 1024 system clock periods before executing
// - vectors: reset 000, external 004, timer0 008, timer1 or converter 00C, converter 010
// - counter width is 10, 11 or 12 bits by variant
// - returns restore the counter from the saved stack value
package fps_pkg;
    localparam int unsigned PC_W = 12;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PHASES = 4;

    localparam logic [11:0] REG_PC_LOW = 12'h000;
    localparam logic [11:0] REG_STAT = 12'h004;
    localparam logic [11:0] REG_CFG = 12'h008;

    localparam logic [7:0] PC_LOW_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [1:0] CFG_VARIANT_RESET = 2'h2;

    localparam int unsigned STAT_RUN_BIT = 0;
    localparam int unsigned STAT_DUMMY_BIT = 1;
    localparam int unsigned STAT_PHASE_LSB = 4;
    localparam int unsigned STAT_PC_LSB = 8;

    localparam logic [11:0] VEC_EXT = 12'h004;
    localparam logic [11:0] VEC_TMR0 = 12'h008;
    localparam logic [11:0] VEC_TMR1 = 12'h00C;
    localparam logic [11:0] VEC_ADC_BIG = 12'h010;

    localparam logic [3:0] PHASE_RESET = 4'h1;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned STARTUP_TSYS = 1024;
    localparam int unsigned STARTUP_CYC = (STARTUP_TSYS * CLK_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_CNT_W = 11;

    typedef enum logic [1:0] {
        FPS_VAR_10,
        FPS_VAR_11,
        FPS_VAR_12
    } fps_variant_t;

    typedef enum logic [1:0] {
        FPS_INT_EXT,
        FPS_INT_TMR0,
        FPS_INT_TMR1,
        FPS_INT_ADC
    } fps_int_src_t;

    typedef enum {
        FPS_ST_RUN,
        FPS_ST_SLEEP,
        FPS_ST_WAKE
    } fps_state_t;
endpackage : fps_pkg

// *** rtl/fps_startup_timer.sv ***
// start-up wait counter used on wake-up from power-down
`timescale 1ns/1ns
module fps_startup_timer
    import fps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    fps_ctl_if.timer ctl
);
    logic [STARTUP_CNT_W-1:0] cnt_q;
    logic [STARTUP_CNT_W-1:0] cnt_d;
    logic done_q;
    logic done_d;

    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (ctl.wake_go) begin
            cnt_d = STARTUP_CNT_W'(STARTUP_CYC);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - STARTUP_CNT_W'(1);
            done_d = (cnt_q == STARTUP_CNT_W'(1));
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign ctl.startup_done = done_q;
endmodule : fps_startup_timer

// *** rtl/fps_top.sv ***
// program counter sequencer with four-phase fetch pipeline and apb register slave
`timescale 1ns/1ns
module fps_top
    import fps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ex_jump,
    input wire logic ex_call,
    input wire logic ex_ret,
    input wire logic ex_skip,
    input wire logic ex_pc_low_wr,
    input wire logic [7:0] ex_pc_low_data,
    input wire logic [11:0] ex_target,
    input wire logic [11:0] ex_stack_pc,
    input wire logic int_ack,
    input wire logic [1:0] int_src,
    input wire logic halt_req,
    input wire logic wake_evt,
    output logic [11:0] fetch_addr,
    output logic fetch_strobe,
    output logic [3:0] phase_clks,
    output logic exec_valid,
    output logic stack_push,
    output logic [11:0] stack_push_data,
    output logic stack_pop,
    output logic running
);
    fps_ctl_if ctl ();

    fps_phase_ring u_ring (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ctl(ctl)
    );

    fps_startup_timer u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ctl(ctl)
    );

    // mask of implemented counter bits for the selected variant
    function automatic logic [11:0] pc_mask(input logic [1:0] variant);
        logic [11:0] m;
        m = 12'hFFF;
        if (variant == FPS_VAR_10) begin
            m = 12'h3FF;
        end else if (variant == FPS_VAR_11) begin
            m = 12'h7FF;
        end
        return m;
    endfunction : pc_mask

    // interrupt vector lookup
    function automatic logic [11:0] int_vector(input logic [1:0] src, input logic [1:0] variant);
        logic [11:0] v;
        v = VEC_EXT;
        case (src)
            FPS_INT_TMR0: v = VEC_TMR0;
            FPS_INT_TMR1: v = VEC_TMR1;
            FPS_INT_ADC: v = (variant == FPS_VAR_10) ? VEC_TMR1 : VEC_ADC_BIG;
            default: v = VEC_EXT;
        endcase
        return v;
    endfunction : int_vector

    // sequencer state
    logic [11:0] pc_q;
    logic [11:0] pc_d;
    logic exec_valid_q;
    logic exec_valid_d;
    logic fetch_q;
    logic fetch_d;
    logic push_q;
    logic push_d;
    logic [11:0] push_data_q;
    logic [11:0] push_data_d;
    logic pop_q;
    logic pop_d;
    logic pend_q;
    logic pend_d;
    logic [7:0] pend_data_q;
    logic [7:0] pend_data_d;
    logic [3:0] phase_q;
    logic [3:0] phase_d;
    fps_state_t state_q;
    fps_state_t state_d;
    logic run_q;
    logic run_d;
    logic wake_go_q;
    logic wake_go_d;

    // register slave state
    logic [1:0] variant_q;
    logic [1:0] variant_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    logic apb_access;
    logic apb_done;
    logic apb_wr_pc_low;
    logic [11:0] mask;

    assign apb_access = psel & penable & ~pready_q;
    // writes commit at the edge where the master sees pready high
    assign apb_done = psel & penable & pready_q;
    assign apb_wr_pc_low = apb_done & pwrite & (paddr == REG_PC_LOW);
    assign mask = pc_mask(variant_q);

    always_comb begin
        pc_d = pc_q;
        exec_valid_d = exec_valid_q;
        fetch_d = 1'b0;
        push_d = 1'b0;
        push_data_d = push_data_q;
        pop_d = 1'b0;
        pend_d = pend_q;
        pend_data_d = pend_data_q;
        state_d = state_q;
        wake_go_d = 1'b0;
        if (ctl.boundary) begin
            fetch_d = 1'b1;
            exec_valid_d = 1'b1;
            if (exec_valid_q && int_ack) begin
                pc_d = int_vector(int_src, variant_q);
                push_d = 1'b1;
                push_data_d = pc_q;
                exec_valid_d = 1'b0;
            end else if (exec_valid_q && (ex_jump || ex_call)) begin
                pc_d = ex_target;
                push_d = ex_call;
                push_data_d = pc_q;
                exec_valid_d = 1'b0;
            end else if (exec_valid_q && ex_ret) begin
                pc_d = ex_stack_pc;
                pop_d = 1'b1;
                exec_valid_d = 1'b0;
            end else if (exec_valid_q && ex_pc_low_wr) begin
                pc_d = {pc_q[11:8], ex_pc_low_data};
                exec_valid_d = 1'b0;
            end else if (pend_q) begin
                pc_d = {pc_q[11:8], pend_data_q};
                pend_d = 1'b0;
                exec_valid_d = 1'b0;
            end else if (exec_valid_q && ex_skip) begin
                // prefetched word at pc_q is dropped, next fetch at pc_q plus one
                pc_d = pc_q + 12'h001;
                exec_valid_d = 1'b0;
            end else begin
                pc_d = pc_q + 12'h001;
            end
            pc_d = pc_d & mask;
            if (exec_valid_q && halt_req && state_q == FPS_ST_RUN) begin
                state_d = FPS_ST_SLEEP;
            end
        end
        if (apb_wr_pc_low) begin
            pend_d = 1'b1;
            pend_data_d = pwdata[7:0];
        end
        case (state_q)
            FPS_ST_SLEEP: begin
                if (wake_evt) begin
                    state_d = FPS_ST_WAKE;
                    wake_go_d = 1'b1;
                end
            end
            FPS_ST_WAKE: begin
                if (ctl.startup_done) begin
                    state_d = FPS_ST_RUN;
                end
            end
            default: begin
            end
        endcase
        run_d = (state_d == FPS_ST_RUN);
        phase_d = ctl.phase;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pc_q <= PC_RESET;
            exec_valid_q <= 1'b0;
            fetch_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= PC_RESET;
            pop_q <= 1'b0;
            pend_q <= 1'b0;
            pend_data_q <= PC_LOW_RESET;
            phase_q <= PHASE_RESET;
            state_q <= FPS_ST_RUN;
            run_q <= 1'b1;
            wake_go_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            exec_valid_q <= exec_valid_d;
            fetch_q <= fetch_d;
            push_q <= push_d;
            push_data_q <= push_data_d;
            pop_q <= pop_d;
            pend_q <= pend_d;
            pend_data_q <= pend_data_d;
            phase_q <= phase_d;
            state_q <= state_d;
            run_q <= run_d;
            wake_go_q <= wake_go_d;
        end
    end

    assign ctl.run = run_q;
    assign ctl.wake_go = wake_go_q;

    // apb slave: one wait state, reads show live state
    always_comb begin
        variant_d = variant_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (apb_access) begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            if (paddr == REG_PC_LOW) begin
                prdata_d[7:0] = pc_q[7:0];
            end else if (paddr == REG_STAT) begin
                prdata_d[STAT_RUN_BIT] = run_q;
                prdata_d[STAT_DUMMY_BIT] = ~exec_valid_q;
                prdata_d[STAT_PHASE_LSB +: 4] = ctl.phase;
                prdata_d[STAT_PC_LSB +: 12] = pc_q;
            end else if (paddr == REG_CFG) begin
                prdata_d[1:0] = variant_q;
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (apb_done && pwrite && paddr == REG_CFG && pwdata[1:0] != 2'h3) begin
            variant_d = pwdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            variant_q <= CFG_VARIANT_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            variant_q <= variant_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fetch_addr = pc_q;
    assign fetch_strobe = fetch_q;
    assign phase_clks = phase_q;
    assign exec_valid = exec_valid_q;
    assign stack_push = push_q;
    assign stack_push_data = push_data_q;
    assign stack_pop = pop_q;
    assign running = run_q;
endmodule : fps_top
